// *** core/adcc_ctrl.sv ***
// converter control/status and result access registers on apb
`timescale 1ns/100ps
module adcc_ctrl
  import adcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adcc_pkg::ADCC_ADDR_W-1:0] paddr,
  input wire logic [adcc_pkg::ADCC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [adcc_pkg::ADCC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adcc_pkg::adcc_conv_s conv_in,
  output adcc_pkg::adcc_afe_s afe_cfg,
  output logic result_valid,
  output logic irq
);
  import adcc_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic [11:0] reg_index;
  logic aligned;
  logic hit_c0;
  logic hit_c1;
  logic hit_hi;
  logic hit_lo;
  logic hit_ist;
  logic hit_imk;
  logic mapped;
  logic setup;
  logic access;
  logic wr_access;
  logic rd_access;
  logic lane0;

  assign reg_index = paddr[13:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr_access = access && pwrite && mapped;
  assign rd_access = access && !pwrite && mapped;
  // only the low byte lane carries register data
  assign lane0 = pstrb[0];

  always_comb
  begin
    hit_c0 = 1'b0;
    hit_c1 = 1'b0;
    hit_hi = 1'b0;
    hit_lo = 1'b0;
    hit_ist = 1'b0;
    hit_imk = 1'b0;
    if (!aligned)
    begin
      hit_c0 = 1'b0;
    end
    else if (reg_index == ADCC_IDX_CTRL_ZERO)
    begin
      hit_c0 = 1'b1;
    end
    else if (reg_index == ADCC_IDX_CTRL_STATUS_ONE)
    begin
      hit_c1 = 1'b1;
    end
    else if (reg_index == ADCC_IDX_RESULT_HIGH)
    begin
      hit_hi = 1'b1;
    end
    else if (reg_index == ADCC_IDX_RESULT_LOW)
    begin
      hit_lo = 1'b1;
    end
    else if (reg_index == ADCC_IDX_IRQ_STATUS)
    begin
      hit_ist = 1'b1;
    end
    else if (reg_index == ADCC_IDX_IRQ_MASK)
    begin
      hit_imk = 1'b1;
    end
  end

  assign mapped = hit_c0 || hit_c1 || hit_hi || hit_lo || hit_ist || hit_imk;

  // one wait-free access phase; unmapped addresses answer with an error
  assign pready = access;
  assign pslverr = access && !mapped;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_zero;
  logic [7:0] ctrl_one;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_zero <= ADCC_C0_RESET;
    end
    else if (wr_access && hit_c0 && lane0)
    begin
      ctrl_zero <= {7'h00, pwdata[ADCC_C0_REF_LO]};
    end
  end

  // status bits 4:3 are not stored here; they read live from the triggers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_one <= ADCC_C1_RESET;
    end
    else if (wr_access && hit_c1 && lane0)
    begin
      ctrl_one <= pwdata[7:0] & ADCC_C1_WR_MASK;
    end
  end

  // ----------------------------------------------------------------
  // analog configuration decode
  // ----------------------------------------------------------------
  logic [1:0] ref_bits;
  logic [2:0] mode_bits;

  // the comparator has its own reference path; nothing here touches it
  assign ref_bits = {ctrl_one[ADCC_C1_REF_HI], ctrl_zero[ADCC_C0_REF_LO]};
  assign mode_bits = ctrl_one[ADCC_C1_MODE_MSB:0];

  always_comb
  begin
    afe_cfg = '0;
    afe_cfg.ref_code = adcc_ref_e'(ref_bits);
    afe_cfg.input_buffer_mode = mode_bits;
    case (adcc_ref_e'(ref_bits))
      ADCC_REF_EXTERNAL: afe_cfg.ref_internal_en = 1'b0;
      ADCC_REF_1V0: afe_cfg.ref_internal_en = 1'b1;
      ADCC_REF_2V0: afe_cfg.ref_internal_en = 1'b1;
      default:
      begin
        // reserved code: keep the internal reference off rather than guess a level
        afe_cfg.ref_internal_en = 1'b0;
        afe_cfg.ref_reserved = 1'b1;
      end
    endcase
    case (mode_bits)
      ADCC_BUF_SE_RAW: afe_cfg.mode_reserved = 1'b0;
      ADCC_BUF_SE_UNITY: afe_cfg.unity_gain = 1'b1;
      ADCC_BUF_DIFF_RAW: afe_cfg.differential = 1'b1;
      ADCC_BUF_DIFF_UNITY:
      begin
        afe_cfg.differential = 1'b1;
        afe_cfg.unity_gain = 1'b1;
      end
      default: afe_cfg.mode_reserved = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // conversion result
  // ----------------------------------------------------------------
  logic [ADCC_RESULT_W-1:0] result;
  logic [ADCC_LOW_W-1:0] low_latch;
  logic have_result;

  // only the converter writes the result; bus writes never reach it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result <= '0;
    end
    else if (conv_in.done)
    begin
      result <= conv_in.result;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      have_result <= 1'b0;
    end
    else if (conv_in.done)
    begin
      have_result <= 1'b1;
    end
  end

  // the low five bits are frozen on the high read so a later result cannot tear the pair
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_latch <= '0;
    end
    else if (rd_access && hit_hi)
    begin
      low_latch <= result[ADCC_LOW_W-1:0];
    end
  end

  assign result_valid = have_result && !conv_in.busy;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic thr_hi_d;
  logic thr_lo_d;
  logic [ADCC_IRQ_N-1:0] irq_event;
  logic [ADCC_IRQ_N-1:0] irq_status;
  logic [ADCC_IRQ_N-1:0] irq_mask;
  logic [ADCC_IRQ_N-1:0] w1c;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      thr_hi_d <= 1'b0;
      thr_lo_d <= 1'b0;
    end
    else
    begin
      thr_hi_d <= conv_in.thr_hi;
      thr_lo_d <= conv_in.thr_lo;
    end
  end

  // threshold events are rising edges, gated by the enables
  assign irq_event[ADCC_IRQ_DONE] = conv_in.done;
  assign irq_event[ADCC_IRQ_THR_HI] = conv_in.thr_hi && !thr_hi_d
                                      && ctrl_one[ADCC_C1_THR_HI_EN];
  assign irq_event[ADCC_IRQ_THR_LO] = conv_in.thr_lo && !thr_lo_d
                                      && ctrl_one[ADCC_C1_THR_LO_EN];
  assign w1c = (wr_access && hit_ist && lane0) ? pwdata[ADCC_IRQ_N-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < ADCC_IRQ_N; gi++)
    begin : g_irq
      // a new event beats a clear in the same cycle
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          irq_status[gi] <= ADCC_IRQ_RESET[gi];
        end
        else if (irq_event[gi])
        begin
          irq_status[gi] <= 1'b1;
        end
        else if (w1c[gi])
        begin
          irq_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_mask <= ADCC_IRQ_RESET;
    end
    else if (wr_access && hit_imk && lane0)
    begin
      irq_mask <= pwdata[ADCC_IRQ_N-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  logic [7:0] ctrl_one_view;
  logic [ADCC_DATA_W-1:0] next_prdata;

  always_comb
  begin
    ctrl_one_view = ctrl_one;
    ctrl_one_view[ADCC_C1_THR_HI_ST] = conv_in.thr_hi;
    ctrl_one_view[ADCC_C1_THR_LO_ST] = conv_in.thr_lo;
  end

  always_comb
  begin
    next_prdata = ADCC_RD_ZERO;
    if (hit_c0)
    begin
      next_prdata[7:0] = ctrl_zero;
    end
    else if (hit_c1)
    begin
      next_prdata[7:0] = ctrl_one_view;
    end
    else if (hit_hi)
    begin
      next_prdata[7:0] = result[ADCC_RESULT_W-1:ADCC_LOW_W];
    end
    else if (hit_lo)
    begin
      next_prdata[7:ADCC_LOW_SHIFT] = low_latch;
    end
    else if (hit_ist)
    begin
      next_prdata[ADCC_IRQ_N-1:0] = irq_status;
    end
    else if (hit_imk)
    begin
      next_prdata[ADCC_IRQ_N-1:0] = irq_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= ADCC_RD_ZERO;
    end
    else if (setup && !pwrite)
    begin
      prdata <= next_prdata;
    end
  end

endmodule

// *** core/adcc_pkg.sv ***
// constants, types and register map of the converter control block
package adcc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADCC_IDX_CTRL_ZERO = 12'h0f70;
  localparam logic [11:0] ADCC_IDX_CTRL_STATUS_ONE = 12'h0f71;
  localparam logic [11:0] ADCC_IDX_RESULT_HIGH = 12'h0f72;
  localparam logic [11:0] ADCC_IDX_RESULT_LOW = 12'h0f73;
  localparam logic [11:0] ADCC_IDX_IRQ_STATUS = 12'h0f74;
  localparam logic [11:0] ADCC_IDX_IRQ_MASK = 12'h0f75;

  localparam int ADCC_ADDR_W = 16;
  localparam int ADCC_DATA_W = 32;
  localparam int ADCC_RESULT_W = 13;
  localparam int ADCC_HIGH_W = 8;
  localparam int ADCC_LOW_W = ADCC_RESULT_W - ADCC_HIGH_W;

  // ----------------------------------------------------------------
  // control/status one field layout
  // ----------------------------------------------------------------
  localparam int ADCC_C1_REF_HI = 7;
  localparam int ADCC_C1_THR_HI_EN = 6;
  localparam int ADCC_C1_THR_LO_EN = 5;
  localparam int ADCC_C1_THR_HI_ST = 4;
  localparam int ADCC_C1_THR_LO_ST = 3;
  localparam int ADCC_C1_MODE_MSB = 2;
  localparam logic [7:0] ADCC_C1_RESET = 8'h0080;
  localparam logic [7:0] ADCC_C1_WR_MASK = 8'h00e7;

  // control zero field layout
  localparam int ADCC_C0_REF_LO = 0;
  localparam logic [7:0] ADCC_C0_RESET = 8'h0000;

  // low bits sit left-aligned in their byte
  localparam int ADCC_LOW_SHIFT = 3;

  // interrupt status / mask bit positions
  localparam int ADCC_IRQ_N = 3;
  localparam int ADCC_IRQ_DONE = 0;
  localparam int ADCC_IRQ_THR_HI = 1;
  localparam int ADCC_IRQ_THR_LO = 2;
  localparam logic [ADCC_IRQ_N-1:0] ADCC_IRQ_RESET = 3'h0;

  localparam logic [ADCC_DATA_W-1:0] ADCC_RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCC_REF_EXTERNAL = 2'h0,
    ADCC_REF_1V0 = 2'h1,
    ADCC_REF_2V0 = 2'h2,
    ADCC_REF_RESERVED = 2'h3
  } adcc_ref_e;

  typedef enum logic [2:0] {
    ADCC_BUF_SE_RAW = 3'h0,
    ADCC_BUF_SE_UNITY = 3'h1,
    ADCC_BUF_DIFF_RAW = 3'h4,
    ADCC_BUF_DIFF_UNITY = 3'h5
  } adcc_buf_e;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADCC_RESULT_W-1:0] result;
    logic done;
    logic busy;
    logic thr_hi;
    logic thr_lo;
  } adcc_conv_s;

  typedef struct packed {
    adcc_ref_e ref_code;
    logic ref_internal_en;
    logic [2:0] input_buffer_mode;
    logic differential;
    logic unity_gain;
    logic mode_reserved;
    logic ref_reserved;
  } adcc_afe_s;

endpackage

// *** dv/adcc_ctrl_props.sv ***
// assertion checker for the converter control block
`timescale 1ns/100ps
module adcc_ctrl_props
  import adcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [adcc_pkg::ADCC_ADDR_W-1:0] paddr,
  input wire logic [adcc_pkg::ADCC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [adcc_pkg::ADCC_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire adcc_pkg::adcc_conv_s conv_in,
  input wire adcc_pkg::adcc_afe_s afe_cfg,
  input wire logic result_valid,
  input wire logic irq
);
  localparam logic [15:0] a_hi = {2'b00, ADCC_IDX_RESULT_HIGH, 2'b00};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------
  // bus, decode and result-valid relations
  // ------------------------------
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_unmapped; psel && penable && !pwrite && paddr == 16'h3dd8 |-> pslverr && prdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_ro_write; psel && penable && pwrite && paddr == a_hi |-> !pslverr; endproperty
  a_ro_write: assert property (p_ro_write) else $error("high byte write errored");
  property p_ref_ext; afe_cfg.ref_code == ADCC_REF_EXTERNAL |-> !afe_cfg.ref_internal_en;
  endproperty
  a_ref_ext: assert property (p_ref_ext) else $error("internal ref on for pin");
  property p_ref_int; afe_cfg.ref_code inside {2'h1, 2'h2} |-> afe_cfg.ref_internal_en;
  endproperty
  a_ref_int: assert property (p_ref_int) else $error("internal ref off");
  property p_ref_rsv; afe_cfg.ref_reserved == (afe_cfg.ref_code == 2'h3); endproperty
  a_ref_rsv: assert property (p_ref_rsv) else $error("ref reserved flag wrong");
  // reserved codes 110/111 leave the differential path off
  property p_diff; afe_cfg.differential == (afe_cfg.input_buffer_mode inside {3'h4, 3'h5});
  endproperty
  a_diff: assert property (p_diff) else $error("differential flag wrong");
  property p_unity; afe_cfg.unity_gain == (afe_cfg.input_buffer_mode inside {3'h1, 3'h5});
  endproperty
  a_unity: assert property (p_unity) else $error("unity gain flag wrong");
  property p_mode_rsv; afe_cfg.mode_reserved == afe_cfg.input_buffer_mode[1]; endproperty
  a_mode_rsv: assert property (p_mode_rsv) else $error("mode reserved flag wrong");
  // one cycle of slack, the valid flag may be registered
  property p_busy; conv_in.busy && $past(conv_in.busy) |-> !result_valid; endproperty
  a_busy: assert property (p_busy) else $error("valid during conversion");
  property p_done; conv_in.done && !conv_in.busy ##1 !conv_in.busy |-> result_valid; endproperty
  a_done: assert property (p_done) else $error("valid missing after done");
endmodule

bind adcc_ctrl adcc_ctrl_props u_adcc_ctrl_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_in(conv_in), .afe_cfg(afe_cfg),
  .result_valid(result_valid), .irq(irq));

// *** dv/adcc_ctrl_bench.sv ***
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adcc_ctrl_bench;
  import adcc_pkg::*;
  localparam logic [15:0] a_c0 = {2'b00, ADCC_IDX_CTRL_ZERO, 2'b00};
  localparam logic [15:0] a_c1 = {2'b00, ADCC_IDX_CTRL_STATUS_ONE, 2'b00};
  localparam logic [15:0] a_hi = {2'b00, ADCC_IDX_RESULT_HIGH, 2'b00};
  localparam logic [15:0] a_lo = {2'b00, ADCC_IDX_RESULT_LOW, 2'b00};
  localparam logic [15:0] a_st = {2'b00, ADCC_IDX_IRQ_STATUS, 2'b00};
  localparam logic [15:0] a_mk = {2'b00, ADCC_IDX_IRQ_MASK, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  adcc_conv_s conv_in = '0;
  adcc_afe_s afe_cfg;
  logic result_valid;
  logic irq;
  int bad_count = 0;
  int tests_run = 0;
  logic [31:0] rd;
  logic er;
  always #5 pclk = ~pclk;
  adcc_ctrl u_adcc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_in(conv_in), .afe_cfg(afe_cfg),
    .result_valid(result_valid), .irq(irq));
  // ------------------------------
  // shared tasks
  // ------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      chk("pready", pready, 1'b1);
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_exp(input logic [15:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", rd, e);
  endtask
  task automatic pulse_done(input logic [12:0] v);
    @(posedge pclk);
    conv_in.result <= v;
    conv_in.done <= 1'b1;
    conv_in.busy <= 1'b0;
    @(posedge pclk);
    conv_in.done <= 1'b0;
    @(negedge pclk);
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_reset();
    rd_exp(a_c1, 32'h0000_0080);
    rd_exp(a_c0, 32'h0000_0000);
    chk("ref_code", afe_cfg.ref_code, ADCC_REF_2V0);
    chk("irq", irq, 1'b0);
  endtask
  task automatic t_ref();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, a_c0, {31'h0, i[0]});
      apb(1'b1, a_c1, {24'h0, i[1], 7'h0});
      @(negedge pclk);
      chk("ref_code", afe_cfg.ref_code, i[1:0]);
      chk("ref_en", afe_cfg.ref_internal_en, i == 1 || i == 2);
      chk("ref_rsv", afe_cfg.ref_reserved, i == 3);
    end
  endtask
  task automatic t_mode();
    for (int m = 0; m < 8; m++)
    begin
      apb(1'b1, a_c1, {24'h0, 5'h10, m[2:0]});
      rd_exp(a_c1, {24'h0, 5'h10, m[2:0]});
      chk("mode", afe_cfg.input_buffer_mode, m[2:0]);
      chk("diff", afe_cfg.differential, m == 4 || m == 5);
      chk("unity", afe_cfg.unity_gain, m == 1 || m == 5);
      chk("mode_rsv", afe_cfg.mode_reserved, m[1]);
    end
    apb(1'b1, a_c1, 32'h0000_00ff);
    rd_exp(a_c1, 32'h0000_00e7);
  endtask
  task automatic t_thr();
    apb(1'b1, a_c1, 32'h0000_00c0);
    conv_in.thr_hi <= 1'b1;
    @(posedge pclk);
    conv_in.thr_lo <= 1'b1;
    rd_exp(a_c1, 32'h0000_00d8);
    rd_exp(a_st, 32'h0000_0002);
    chk("irq", irq, 1'b0);
    apb(1'b1, a_mk, 32'h0000_0002);
    @(negedge pclk);
    chk("irq", irq, 1'b1);
    apb(1'b1, a_st, 32'h0000_0002);
    @(negedge pclk);
    chk("irq", irq, 1'b0);
    rd_exp(a_st, 32'h0000_0000);
    conv_in.thr_hi <= 1'b0;
    conv_in.thr_lo <= 1'b0;
  endtask
  task automatic t_res();
    logic [12:0] v1 = 13'h1a5b;
    logic [12:0] v2 = 13'h0123;
    conv_in.busy <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk("valid", result_valid, 1'b0);
    pulse_done(v1);
    @(negedge pclk);
    chk("valid", result_valid, 1'b1);
    rd_exp(a_hi, {24'h0, v1[12:5]});
    // a newer result must not leak into the latched low bits
    pulse_done(v2);
    rd_exp(a_lo, {24'h0, v1[4:0], 3'h0});
    apb(1'b1, a_hi, 32'h0000_00ff);
    chk("pslverr", er, 1'b0);
    rd_exp(a_hi, {24'h0, v2[12:5]});
    apb(1'b0, 16'h3dd8, 32'h0000_0000);
    chk("pslverr", er, 1'b1);
    chk("prdata", rd, 32'h0000_0000);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ref();
    t_mode();
    t_thr();
    t_res();
    complete_run();
  end
endmodule
